// *** core/bsma_params.svh ***
// Constants of the boot select and code area alias block.
// Assumes a 32-bit byte address space and a 200 MHz system clock.
`ifndef BSMA_PARAMS_SVH
`define BSMA_PARAMS_SVH

// ============================================================
// Register offsets and fields
`define BSMA_REG_REMAP       8'h00
`define BSMA_REG_STATUS      8'h04
`define BSMA_REMAP_MSB       2
`define BSMA_REMAP_LSB       0
`define BSMA_REMAP_RESET     3'h0
`define BSMA_STAT_PIN        0
`define BSMA_STAT_HIGH       1
`define BSMA_STAT_BANK2      2
`define BSMA_STAT_MODE_MSB   6
`define BSMA_STAT_MODE_LSB   4
`define BSMA_STAT_READY      8

// ============================================================
// Timing: settle time after reset or wakeup before capture
`define BSMA_SETTLE_NS       20
`define BSMA_CLK_MHZ         200
`define BSMA_SETTLE_CYCLES   ((`BSMA_SETTLE_NS * `BSMA_CLK_MHZ + 999) / 1000)

// ============================================================
// Native memory ranges
`define BSMA_FLASH_BASE      32'h0800_0000
`define BSMA_FLASH_LAST      32'h080f_ffff
`define BSMA_SYS_BASE        32'h1fff_0000
`define BSMA_SYS_LAST        32'h1fff_ffff
`define BSMA_SRAM1_BASE      32'h2000_0000
`define BSMA_SRAM1_LAST      32'h2001_7fff
`define BSMA_SRAM2_BASE      32'h1000_0000
`define BSMA_SRAM2_LAST      32'h1000_7fff
`define BSMA_XSM_BASE        32'h6000_0000
`define BSMA_XSM_LAST        32'h67ff_ffff
`define BSMA_QSF_BASE        32'h9000_0000
`define BSMA_QSF_LAST        32'h9fff_ffff

// ============================================================
// Alias window at address zero
`define BSMA_ZERO            32'h0000_0000
`define BSMA_ALIAS_FLASH     32'h000f_ffff
`define BSMA_ALIAS_SRAM1     32'h0001_7fff
`define BSMA_ALIAS_SYS       32'h0000_6fff
`define BSMA_CODE_LAST       32'h07ff_ffff

`endif

// *** core/bsma_pkg.sv ***
// Types shared by the boot select and code area alias block.
// Assumes the constants header is included by the design files.
package bsma_pkg;

    // ============================================================
    // Memory a request lands in
    typedef enum logic [2:0] {
        BSMA_TGT_NONE,
        BSMA_TGT_FLASH,
        BSMA_TGT_SYSMEM,
        BSMA_TGT_SRAM1,
        BSMA_TGT_SRAM2,
        BSMA_TGT_XSM,
        BSMA_TGT_QSF
    } bsma_target_t;

    // ============================================================
    // Memory placed in the code area
    typedef enum logic [2:0] {
        BSMA_MAP_FLASH,
        BSMA_MAP_SYSMEM,
        BSMA_MAP_SRAM1,
        BSMA_MAP_XSM,
        BSMA_MAP_QSF
    } bsma_map_t;

    // ============================================================
    // Boot capture sequencer
    typedef enum logic [1:0] {
        BSMA_ST_SETTLE,
        BSMA_ST_CAPTURE,
        BSMA_ST_RUN
    } bsma_state_t;

    typedef struct packed {
        logic        valid;
        logic        instrBus;
        logic [31:0] addr;
    } bsma_req_t;

    typedef struct packed {
        logic         valid;
        logic         err;
        bsma_target_t target;
        logic [31:0]  offset;
    } bsma_resp_t;

endpackage : bsma_pkg

// *** core/bsma_sync2.sv ***
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input is a pin with no relation to clk.
`timescale 1ns/1ps
`default_nettype none

module bsma_sync2 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Level in and out
    input  wire logic din,
    output logic      dout
);

    logic [1:0] stage_reg;

    // ============================================================
    // Shift chain; only the last stage is read outside
    // One process owns the whole chain, so no bit has two drivers
    always_ff @(posedge clk) begin
        if (srst) begin
            stage_reg <= 2'h0;
        end else begin
            stage_reg <= {stage_reg[0], din};
        end
    end

    assign dout = stage_reg[1];

endmodule : bsma_sync2
`default_nettype wire

// *** core/bsma_boot_alias.sv ***
// Boot mode capture, code area remap and address decode for the core.
// Assumes the core waits for bootReady before its first fetch, and
// that the option bits come from logic on clk.
//
// Summary of operation
// RL1: Latched boot pin low selects main flash at zero, any high select.
// RL2: Pin high and high select low put system memory at zero.
// RL3: Pin high and high select high put SRAM1 at zero.
// RL4: High boot select is the inverse of the stored inverted option bit.
// RL5: Pin and option bit are captured once after reset and held.
// RL6: Every Standby exit samples them again and redoes the selection.
// RL7: Outside keeps pin and option bit steady throughout Standby.
// RL8: After settle, core reads stack pointer at zero, vector at next word.
// RL9: Flash boot decodes flash at zero and at its own base.
// RL10: System boot maps system memory at zero and keeps its base.
// RL11: SRAM boot maps SRAM1 at zero and keeps its base.
// RL12: Second bank bit with flash pins starts from system memory.
// RL13: Software remap register picks which memory fills the code area.
// RL14: SRAM1 range decodes in every mode.
// RL15: System memory, OTP and option bytes range decodes in every mode.
// RL16: SRAM2 decodes in every mode; the span above it is reserved.
// RL17: Main flash decodes in every mode; the span above it is reserved.
// RL18: Alias spans 1 Mbyte, 96 Kbyte or 28 Kbyte; rest reserved.
// RL19: External static memory alias covers two 64 Mbyte regions.
// RL20: Quad serial flash alias covers 128 Mbytes.
// RL21: External remap is reached by the instruction bus; native stays.
// RL22: Reserved addresses answer with an error, never memory data.
`timescale 1ns/1ps
`default_nettype none
`include "bsma_params.svh"

module bsma_boot_alias
    import bsma_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Boot straps and power events
    input  wire logic       bootSelectPin,
    input  wire logic       invertedBootOptionBit,
    input  wire logic       secondBankBootBit,
    input  wire logic       standbyExit,
    // Core fetch and data requests
    input  wire bsma_req_t  codeReq,
    output bsma_resp_t      codeResp,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic       regWrStrobe,
    input  wire logic       regRdStrobe,
    output logic [31:0]     regRdData,
    // Boot status
    output logic            bootReady,
    output bsma_map_t       bootMode
);

    // ============================================================
    // Declarations
    localparam logic [2:0] SettleLast = 3'(`BSMA_SETTLE_CYCLES - 1);

    logic         pinSync;
    bsma_state_t  state_reg;
    bsma_state_t  state_next;
    logic [2:0]   settleCnt_reg;
    logic         pinLatched_reg;
    logic         highSel_reg;
    logic         bank2_reg;
    bsma_map_t    bootMode_reg;
    bsma_map_t    remap_reg;
    logic         ready_reg;
    bsma_map_t    captureMode;
    logic         highSelNow;
    logic         remapWrite;
    logic [2:0]   remapField;
    bsma_target_t decTarget;
    logic [31:0]  decOffset;
    logic [31:0]  rdValue;
    bsma_resp_t   resp_reg;
    logic [31:0]  rdData_reg;

    // ============================================================
    // Helpers
    function automatic logic inRange(
        input logic [31:0] a,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    function automatic logic legalMap(input logic [2:0] code);
        legalMap = (code <= 3'(BSMA_MAP_QSF));
    endfunction : legalMap

    // ============================================================
    // Pin synchroniser; option bits are already on clk
    bsma_sync2 u_pinSync (
        .clk  (clk),
        .srst (srst),
        .din  (bootSelectPin),
        .dout (pinSync)
    );

    // ============================================================
    // Capture sequencer
    // Settling covers the synchroniser depth so a stale pin
    // value from before reset is never captured.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BSMA_ST_SETTLE: begin
                if (settleCnt_reg == SettleLast) begin
                    state_next = BSMA_ST_CAPTURE;
                end
            end
            BSMA_ST_CAPTURE: begin
                state_next = BSMA_ST_RUN;
            end
            BSMA_ST_RUN: begin
                state_next = BSMA_ST_RUN;
            end
            default: begin
                state_next = BSMA_ST_SETTLE;
            end
        endcase
        if (standbyExit) begin
            state_next = BSMA_ST_SETTLE; // RL6
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= BSMA_ST_SETTLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            settleCnt_reg <= 3'h0;
        end else if (standbyExit || state_reg != BSMA_ST_SETTLE) begin
            settleCnt_reg <= 3'h0;
        end else if (settleCnt_reg != SettleLast) begin
            settleCnt_reg <= settleCnt_reg + 3'h1;
        end
    end

    // ============================================================
    // Boot mode from straps
    assign highSelNow = ~invertedBootOptionBit; // RL4

    always_comb begin
        if (!pinSync) begin
            if (secondBankBootBit) begin
                captureMode = BSMA_MAP_SYSMEM; // RL12
            end else begin
                captureMode = BSMA_MAP_FLASH; // RL1
            end
        end else if (!highSelNow) begin
            captureMode = BSMA_MAP_SYSMEM; // RL2
        end else begin
            captureMode = BSMA_MAP_SRAM1; // RL3
        end
    end

    // Held until the next reset or Standby exit
    always_ff @(posedge clk) begin
        if (srst) begin
            pinLatched_reg <= 1'b0;
            highSel_reg    <= 1'b0;
            bank2_reg      <= 1'b0;
            bootMode_reg   <= BSMA_MAP_FLASH;
        end else if (state_reg == BSMA_ST_CAPTURE) begin
            pinLatched_reg <= pinSync; // RL5
            highSel_reg    <= highSelNow;
            bank2_reg      <= secondBankBootBit;
            bootMode_reg   <= captureMode;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ready_reg <= 1'b0;
        end else if (standbyExit) begin
            ready_reg <= 1'b0; // RL8
        end else if (state_reg == BSMA_ST_CAPTURE) begin
            ready_reg <= 1'b1; // RL8
        end
    end

    // ============================================================
    // Remap register
    // A capture overrides a software write in the same cycle, so
    // the code area after wakeup always follows the straps.
    assign remapWrite = regWrStrobe && (regAddr == `BSMA_REG_REMAP);
    assign remapField = regWrData[`BSMA_REMAP_MSB:`BSMA_REMAP_LSB];

    always_ff @(posedge clk) begin
        if (srst) begin
            remap_reg <= bsma_map_t'(`BSMA_REMAP_RESET);
        end else if (state_reg == BSMA_ST_CAPTURE) begin
            remap_reg <= captureMode; // RL6
        end else if (remapWrite && legalMap(remapField)) begin
            remap_reg <= bsma_map_t'(remapField); // RL13
        end
    end

    // ============================================================
    // Address decode
    // Native ranges win over the alias window; they never overlap it.
    always_comb begin
        decTarget = BSMA_TGT_NONE;
        decOffset = 32'h0;
        if (inRange(codeReq.addr, `BSMA_SRAM1_BASE, `BSMA_SRAM1_LAST)) begin
            decTarget = BSMA_TGT_SRAM1; // RL14
            decOffset = codeReq.addr - `BSMA_SRAM1_BASE;
        end else if (inRange(codeReq.addr, `BSMA_SYS_BASE, `BSMA_SYS_LAST)) begin
            decTarget = BSMA_TGT_SYSMEM; // RL15
            decOffset = codeReq.addr - `BSMA_SYS_BASE;
        end else if (inRange(codeReq.addr, `BSMA_SRAM2_BASE, `BSMA_SRAM2_LAST)) begin
            decTarget = BSMA_TGT_SRAM2; // RL16
            decOffset = codeReq.addr - `BSMA_SRAM2_BASE;
        end else if (inRange(codeReq.addr, `BSMA_FLASH_BASE, `BSMA_FLASH_LAST)) begin
            decTarget = BSMA_TGT_FLASH; // RL17
            decOffset = codeReq.addr - `BSMA_FLASH_BASE;
        end else if (inRange(codeReq.addr, `BSMA_XSM_BASE, `BSMA_XSM_LAST)) begin
            decTarget = BSMA_TGT_XSM; // RL21
            decOffset = codeReq.addr - `BSMA_XSM_BASE;
        end else if (inRange(codeReq.addr, `BSMA_QSF_BASE, `BSMA_QSF_LAST)) begin
            decTarget = BSMA_TGT_QSF; // RL21
            decOffset = codeReq.addr - `BSMA_QSF_BASE;
        end else if (inRange(codeReq.addr, `BSMA_ZERO, `BSMA_CODE_LAST)) begin
            case (remap_reg)
                BSMA_MAP_FLASH: begin
                    if (inRange(codeReq.addr, `BSMA_ZERO, `BSMA_ALIAS_FLASH)) begin
                        decTarget = BSMA_TGT_FLASH; // RL9
                        decOffset = codeReq.addr; // RL18
                    end
                end
                BSMA_MAP_SYSMEM: begin
                    if (inRange(codeReq.addr, `BSMA_ZERO, `BSMA_ALIAS_SYS)) begin
                        decTarget = BSMA_TGT_SYSMEM; // RL10
                        decOffset = codeReq.addr; // RL18
                    end
                end
                BSMA_MAP_SRAM1: begin
                    if (inRange(codeReq.addr, `BSMA_ZERO, `BSMA_ALIAS_SRAM1)) begin
                        decTarget = BSMA_TGT_SRAM1; // RL11
                        decOffset = codeReq.addr; // RL18
                    end
                end
                BSMA_MAP_XSM: begin
                    // Region 1 low, region 2 above; offset keeps the split
                    if (codeReq.instrBus) begin
                        decTarget = BSMA_TGT_XSM; // RL19 RL21
                        decOffset = codeReq.addr;
                    end
                end
                BSMA_MAP_QSF: begin
                    if (codeReq.instrBus) begin
                        decTarget = BSMA_TGT_QSF; // RL20 RL21
                        decOffset = codeReq.addr;
                    end
                end
                default: begin
                    decTarget = BSMA_TGT_NONE;
                end
            endcase
        end
    end

    // ============================================================
    // Registered answer to the core
    // Before capture the alias is not yet valid, so every access
    // errors rather than fetching from a guessed memory.
    always_ff @(posedge clk) begin
        if (srst) begin
            resp_reg <= '0;
        end else begin
            resp_reg.valid <= codeReq.valid;
            if (codeReq.valid && ready_reg && decTarget != BSMA_TGT_NONE) begin
                resp_reg.err    <= 1'b0;
                resp_reg.target <= decTarget;
                resp_reg.offset <= decOffset;
            end else begin
                resp_reg.err    <= codeReq.valid; // RL22
                resp_reg.target <= BSMA_TGT_NONE;
                resp_reg.offset <= 32'h0;
            end
        end
    end

    // ============================================================
    // Register read
    always_comb begin
        rdValue = 32'h0;
        if (regAddr == `BSMA_REG_REMAP) begin
            rdValue[`BSMA_REMAP_MSB:`BSMA_REMAP_LSB] = remap_reg;
        end else if (regAddr == `BSMA_REG_STATUS) begin
            rdValue[`BSMA_STAT_PIN]   = pinLatched_reg;
            rdValue[`BSMA_STAT_HIGH]  = highSel_reg;
            rdValue[`BSMA_STAT_BANK2] = bank2_reg;
            rdValue[`BSMA_STAT_MODE_MSB:`BSMA_STAT_MODE_LSB] = bootMode_reg;
            rdValue[`BSMA_STAT_READY] = ready_reg;
        end
    end

    // Data stand for one cycle only; zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rdData_reg <= 32'h0;
        end else if (regRdStrobe) begin
            rdData_reg <= rdValue;
        end else begin
            rdData_reg <= 32'h0;
        end
    end

    // ============================================================
    // Outputs
    assign codeResp  = resp_reg;
    assign regRdData = rdData_reg;
    assign bootReady = ready_reg;
    assign bootMode  = bootMode_reg;

endmodule : bsma_boot_alias
`default_nettype wire

// *** sim/bsma_boot_alias_chk.sv ***
// Concurrent checks on the boot select and code alias block.
// Assumes it is bound to bsma_boot_alias and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "bsma_params.svh"

module bsma_boot_alias_chk
    import bsma_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Straps and power events
    input wire logic        bootSelectPin,
    input wire logic        invertedBootOptionBit,
    input wire logic        secondBankBootBit,
    input wire logic        standbyExit,
    // Code port
    input wire bsma_req_t   codeReq,
    input wire bsma_resp_t  codeResp,
    // Register port
    input wire logic        regRdStrobe,
    input wire logic [31:0] regRdData,
    // Status
    input wire logic        bootReady,
    input wire bsma_map_t   bootMode
);
    // ============================================================
    // Helpers
    wire logic [31:0] a  = codeReq.addr;
    wire logic        rq = codeReq.valid && bootReady;
    // Straps settle well before capture, so a fixed look-back suffices
    bsma_map_t        expMode;
    assign expMode = bootSelectPin ? (invertedBootOptionBit ? BSMA_MAP_SYSMEM : BSMA_MAP_SRAM1)
                   : (secondBankBootBit ? BSMA_MAP_SYSMEM : BSMA_MAP_FLASH);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ============================================================
    // Properties
    chk_resp_one_later: assert property (codeReq.valid |=> codeResp.valid)
        else $error("no response");
    chk_resp_quiet: assert property (!codeReq.valid |=> !codeResp.valid)
        else $error("stray response");
    chk_sram1_native: assert property (rq && a inside {[`BSMA_SRAM1_BASE:`BSMA_SRAM1_LAST]}
        |=> !codeResp.err && codeResp.target == BSMA_TGT_SRAM1
        && codeResp.offset == $past(a) - `BSMA_SRAM1_BASE) else $error("sram1 decode");
    chk_sys_native: assert property (rq && a inside {[`BSMA_SYS_BASE:`BSMA_SYS_LAST]}
        |=> !codeResp.err && codeResp.target == BSMA_TGT_SYSMEM
        && codeResp.offset == $past(a) - `BSMA_SYS_BASE) else $error("sysmem decode");
    chk_flash_native: assert property (rq && a inside {[`BSMA_FLASH_BASE:`BSMA_FLASH_LAST]}
        |=> !codeResp.err && codeResp.target == BSMA_TGT_FLASH
        && codeResp.offset == $past(a) - `BSMA_FLASH_BASE) else $error("flash decode");
    chk_resv_err: assert property (rq && a inside {[32'h1000_8000:32'h1ffe_ffff],
        [32'h0810_0000:32'h0fff_ffff]} |=> codeResp.err
        && codeResp.target == BSMA_TGT_NONE) else $error("reserved not refused");
    chk_mode_decode: assert property ($rose(bootReady) |-> bootMode == $past(expMode, 4))
        else $error("boot mode decode");
    chk_mode_hold: assert property (bootReady && !standbyExit |=> $stable(bootMode))
        else $error("boot mode moved");
    chk_wake_recap: assert property (standbyExit |=> !bootReady ##[1:12] bootReady)
        else $error("no recapture on wakeup");
    chk_rd_idle: assert property (!regRdStrobe |=> regRdData == 32'h0)
        else $error("read data outside slot");
endmodule : bsma_boot_alias_chk

bind bsma_boot_alias bsma_boot_alias_chk u_chk (
    .clk, .srst, .bootSelectPin, .invertedBootOptionBit, .secondBankBootBit, .standbyExit,
    .codeReq, .codeResp, .regRdStrobe, .regRdData, .bootReady, .bootMode
);
`default_nettype wire

// *** sim/bsma_core_model.sv ***
// Behavioural core that fetches from the code area.
// Assumes one access at a time; the bench waits for boot fetches to end.
`timescale 1ns/1ps
`default_nettype none

module bsma_core_model
    import bsma_pkg::*;
(
    // Clock and status
    input wire logic       clk,
    input wire logic       bootReady,
    // Code port
    input wire bsma_resp_t codeResp,
    output bsma_req_t      codeReq,
    // Boot fetch results
    output int             bootFetches,
    output bsma_resp_t     stackResp,
    output bsma_resp_t     vectorResp
);
    initial begin
        codeReq = '0;
        bootFetches = 0;
    end

    // ============================================================
    // One access; a released address shows its inverse
    task automatic access(input logic [31:0] a, input logic ib, output bsma_resp_t r);
        @(posedge clk);
        codeReq <= '{1'b1, ib, a};
        @(posedge clk);
        codeReq <= '{1'b0, ib, ~a};
        @(negedge clk);
        r = codeResp;
    endtask : access

    // ============================================================
    // Stack pointer, then reset vector, on every boot
    always begin
        @(posedge bootReady);
        access(32'h0000_0000, 1'b1, stackResp);
        access(32'h0000_0004, 1'b1, vectorResp);
        bootFetches++;
    end
endmodule : bsma_core_model
`default_nettype wire

// *** sim/tb_bsma_boot_alias.sv ***
// Self-checking bench for the boot select and code alias block.
// Assumes the core model drives the code port and the bench the rest.
`timescale 1ns/1ps
`default_nettype none
`include "bsma_params.svh"

module tb_bsma_boot_alias
    import bsma_pkg::*;
;
    logic        clk, srst, pin, inv, bank, stbyExit, regWr, regRd, bootReady;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData;
    bsma_map_t   bootMode;
    bsma_req_t   codeReq;
    bsma_resp_t  codeResp, stackResp, vectorResp;
    int          bootFetches, failures, testsRun;

    bsma_boot_alias u_dut (.clk, .srst, .bootSelectPin(pin), .invertedBootOptionBit(inv),
        .secondBankBootBit(bank), .standbyExit(stbyExit), .codeReq, .codeResp, .regAddr,
        .regWrData, .regWrStrobe(regWr), .regRdStrobe(regRd), .regRdData, .bootReady,
        .bootMode);
    bsma_core_model u_core (.clk, .bootReady, .codeResp, .codeReq, .bootFetches, .stackResp,
        .vectorResp);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ============================================================
    // Helpers
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32

    task automatic cmp_resp(input bsma_resp_t got, input bsma_resp_t exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_resp

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask : reg_read

    task automatic code(input logic [31:0] a, input logic ib, input logic e,
        input bsma_target_t t, input logic [31:0] o);
        bsma_resp_t r;
        u_core.access(a, ib, r);
        cmp_resp(r, '{1'b1, e, t, o});
    endtask : code

    task automatic wait_boot(input int n);
        for (int k = 0; bootFetches == n && k < 40; k++) @(posedge clk);
        cmp32({31'h0, bootFetches != n}, 32'h1);
    endtask : wait_boot

    // Targets follow map codes, with SRAM2 sitting between the internal and external ones
    function automatic bsma_target_t tgt_of(input bsma_map_t m);
        return bsma_target_t'((m < BSMA_MAP_XSM) ? m + 1 : m + 2);
    endfunction : tgt_of

    function automatic bsma_map_t exp_mode(input logic p, input logic nb, input logic b2);
        if (p) return nb ? BSMA_MAP_SYSMEM : BSMA_MAP_SRAM1;
        return b2 ? BSMA_MAP_SYSMEM : BSMA_MAP_FLASH;
    endfunction : exp_mode

    // ============================================================
    // Scenarios
    task automatic test_boot_modes;
        bsma_map_t   m;
        logic [31:0] d;
        int          n;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {pin, inv, bank} <= i[2:0];
            repeat (4) @(posedge clk);
            n = bootFetches;
            stbyExit <= 1'b1;
            @(posedge clk);
            stbyExit <= 1'b0;
            wait_boot(n);
            m = exp_mode(i[2], i[1], i[0]);
            cmp32({29'h0, bootMode}, {29'h0, m});
            cmp_resp(stackResp, '{1'b1, 1'b0, tgt_of(m), 32'h0});
            cmp_resp(vectorResp, '{1'b1, 1'b0, tgt_of(m), 32'h4});
            reg_read(`BSMA_REG_STATUS, d);
            cmp32(d, {23'h0, 1'b1, 1'b0, m, 1'b0, i[0], ~i[1], i[2]});
            reg_read(`BSMA_REG_REMAP, d);
            cmp32(d, {29'h0, m});
            {pin, inv, bank} <= ~i[2:0];
            repeat (6) @(posedge clk);
            cmp32({29'h0, bootMode}, {29'h0, m});
        end
        $display("test boot modes done");
    endtask : test_boot_modes

    task automatic test_native;
        code(32'h2000_0000, 1'b0, 1'b0, BSMA_TGT_SRAM1, 32'h0);
        code(32'h2001_7ffc, 1'b0, 1'b0, BSMA_TGT_SRAM1, 32'h1_7ffc);
        code(32'h1fff_0000, 1'b0, 1'b0, BSMA_TGT_SYSMEM, 32'h0);
        code(32'h1fff_fffc, 1'b0, 1'b0, BSMA_TGT_SYSMEM, 32'hfffc);
        code(32'h1000_7ffc, 1'b0, 1'b0, BSMA_TGT_SRAM2, 32'h7ffc);
        code(32'h1000_8000, 1'b0, 1'b1, BSMA_TGT_NONE, 32'h0);
        code(32'h080f_fffc, 1'b0, 1'b0, BSMA_TGT_FLASH, 32'hf_fffc);
        code(32'h0810_0000, 1'b0, 1'b1, BSMA_TGT_NONE, 32'h0);
        $display("test native done");
    endtask : test_native

    task automatic test_remap;
        logic [31:0] d, top;
        bsma_map_t   m;
        for (int k = 0; k < 5; k++) begin
            m = bsma_map_t'(k);
            reg_write(`BSMA_REG_REMAP, 32'(k));
            reg_read(`BSMA_REG_REMAP, d);
            cmp32(d, 32'(k));
            top = (m == BSMA_MAP_FLASH) ? `BSMA_ALIAS_FLASH : (m == BSMA_MAP_SRAM1) ?
                `BSMA_ALIAS_SRAM1 : (m == BSMA_MAP_SYSMEM) ? `BSMA_ALIAS_SYS : `BSMA_CODE_LAST;
            code(top - 3, 1'b1, 1'b0, tgt_of(m), top - 3);
            if (k > 2) begin
                code(32'h0400_0000, 1'b0, 1'b1, BSMA_TGT_NONE, 32'h0);
                code(32'h0400_0000, 1'b1, 1'b0, tgt_of(m), 32'h0400_0000);
            end else begin
                code(top + 1, 1'b1, 1'b1, BSMA_TGT_NONE, 32'h0);
            end
        end
        code(`BSMA_XSM_BASE + 4, 1'b0, 1'b0, BSMA_TGT_XSM, 32'h4);
        code(`BSMA_QSF_BASE + 4, 1'b0, 1'b0, BSMA_TGT_QSF, 32'h4);
        reg_write(`BSMA_REG_REMAP, 32'h5);
        reg_read(`BSMA_REG_REMAP, d);
        cmp32(d, 32'h4);
        reg_write(8'h10, 32'h3);
        reg_read(8'h10, d);
        cmp32(d, 32'h0);
        $display("test remap done");
    endtask : test_remap

    task automatic test_rearm;
        bsma_resp_t r;
        int         n;
        n = bootFetches;
        @(posedge clk);
        {pin, inv, bank} <= 3'b100;
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        u_core.access(32'h0, 1'b1, r);
        cmp_resp(r, '{1'b1, 1'b1, BSMA_TGT_NONE, 32'h0});
        wait_boot(n);
        cmp32({29'h0, bootMode}, {29'h0, BSMA_MAP_SRAM1});
        cmp_resp(vectorResp, '{1'b1, 1'b0, BSMA_TGT_SRAM1, 32'h4});
        $display("test rearm done");
    endtask : test_rearm

    task close_out;
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // ============================================================
    // Main sequence and watchdog
    initial begin
        failures = 0;
        testsRun = 0;
        srst = 1'b1;
        {pin, inv, bank, stbyExit, regWr, regRd, regAddr, regWrData} = 46'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        wait_boot(0);
        cmp_resp(stackResp, '{1'b1, 1'b0, BSMA_TGT_FLASH, 32'h0});
        test_boot_modes();
        test_native();
        test_remap();
        test_rearm();
        close_out();
    end

    initial begin
        #100us;
        failures++;
        close_out();
    end
endmodule : tb_bsma_boot_alias
`default_nettype wire
